// file: hw/ccbs_pkg.sv
package ccbs_pkg;

  // ****************************************
  // Opcode word fields
  // ****************************************
  localparam logic [3:0]  CCBS_FLINE          = 4'hf;
  localparam int          CCBS_FLINE_MSB      = 15;
  localparam int          CCBS_FLINE_LSB      = 12;
  localparam int          CCBS_ID_MSB         = 11;
  localparam int          CCBS_ID_LSB         = 9;
  localparam int          CCBS_TYPE_MSB       = 8;
  localparam int          CCBS_TYPE_LSB       = 6;
  localparam int          CCBS_SEL_MSB        = 5;
  localparam logic [2:0]  CCBS_TYPE_SET_BYTE  = 3'h1;
  localparam logic [2:0]  CCBS_TYPE_BR_SHORT  = 3'h2;
  localparam logic [2:0]  CCBS_TYPE_BR_LONG   = 3'h3;

  // ****************************************
  // Interface register selects
  // ****************************************
  localparam logic [1:0]  CCBS_CIR_COND       = 2'h0;
  localparam logic [1:0]  CCBS_CIR_RESP       = 2'h1;
  localparam logic [1:0]  CCBS_CIR_OPND       = 2'h2;

  // ****************************************
  // Response primitives
  // ****************************************
  localparam int          CCBS_PRIM_MSB       = 15;
  localparam int          CCBS_PRIM_LSB       = 14;
  localparam logic [1:0]  CCBS_PRIM_BUSY      = 2'h0;
  localparam logic [1:0]  CCBS_PRIM_XFER      = 2'h1;
  localparam logic [1:0]  CCBS_PRIM_NULL      = 2'h2;
  localparam logic [15:0] CCBS_RESP_BUSY      = 16'h0000;
  localparam logic [15:0] CCBS_RESP_XFER      = 16'h4000;
  localparam logic [15:0] CCBS_RESP_FALSE     = 16'h8000;
  localparam logic [15:0] CCBS_RESP_TRUE      = 16'h8001;

  // ****************************************
  // Byte values, parameter defaults, counts
  // ****************************************
  localparam logic [7:0]  CCBS_BYTE_TRUE      = 8'hff;
  localparam logic [7:0]  CCBS_BYTE_FALSE     = 8'h00;
  localparam logic [31:0] CCBS_WORD_STEP      = 32'h0000_0002;
  localparam logic [2:0]  CCBS_EA_EXT_MAX     = 3'h5;
  localparam logic [2:0]  CCBS_DEF_CP_ID      = 3'h1;
  localparam int          CCBS_DEF_EXT_WORDS  = 0;
  localparam int          CCBS_DEF_EVAL_CYC   = 2;

  typedef enum logic [3:0] {
    DEV_IDLE, DEV_OPCODE, DEV_SELECTOR, DEV_WR_COND, DEV_RD_RESP,
    DEV_EXT, DEV_WR_OPND, DEV_DISP, DEV_EA_EXT, DEV_FINISH
  } ccbs_dev_state_e;

  typedef enum logic [1:0] {
    COP_IDLE, COP_XFER, COP_EVAL, COP_DONE
  } ccbs_cop_state_e;

endpackage : ccbs_pkg

// file: hw/ccbs_cir_if.sv
`timescale 1ns/1ns
interface ccbs_cir_if;
  logic        cir_req;
  logic        cir_write;
  logic [1:0]  cir_sel;
  logic [2:0]  cir_addr_id;
  logic [15:0] cir_wdata;
  logic [15:0] cir_rdata;
  logic        cir_ack;

  modport dev (output cir_req, output cir_write, output cir_sel, output cir_addr_id,
               output cir_wdata, input cir_rdata, input cir_ack);
  modport cop (input cir_req, input cir_write, input cir_sel, input cir_addr_id,
               input cir_wdata, output cir_rdata, output cir_ack);
endinterface : ccbs_cir_if

// file: hw/ccbs_branch_target.sv
`timescale 1ns/1ns
module ccbs_branch_target (
  // Displacement words
  input  wire logic        disp_long,
  input  wire logic [15:0] disp_hi,
  input  wire logic [15:0] disp_lo,
  // Base address and result
  input  wire logic [31:0] base_addr,
  output logic      [31:0] target_addr
);

  wire logic [31:0] disp_ext;

  assign disp_ext    = disp_long ? {disp_hi, disp_lo} : {{16{disp_hi[15]}}, disp_hi};
  assign target_addr = base_addr + disp_ext;

endmodule : ccbs_branch_target

// file: hw/ccbs_dev.sv
// Functional notes
// - F-line opcode, selector id in bits 11:9
// - Bits 8:6 pick short or long branch
// - Branch writes whole opcode to condition register
// - Coprocessor evaluates low six selector bits
// - Coprocessor words precede final displacement words
// - Read response register after condition write
// - Coprocessor may request services via primitives
// - False branch continues with next instruction
// - True branch target is scan counter plus displacement
// - Scan counter points at first displacement word
// - Displacement signed, short form sign-extended
// - Bits 8:6 equal 001 mean set byte
// - Selector word low six bits, rest reserved
// - Set byte writes selector word to register
// - Up to five address words after coprocessor words
// - False result writes all-zero byte
// - True result writes all-ones byte
// - Null primitive carries final true/false result
// - Selector id driven on every register access
`timescale 1ns/1ns
module ccbs_dev (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Instruction start
  input  wire logic              start,
  input  wire logic [31:0]       pc_start,
  input  wire logic [2:0]        ea_ext_count,
  // Instruction word stream
  input  wire logic              iw_valid,
  input  wire logic [15:0]       iw_data,
  output logic                   iw_ready,
  // Completion
  output logic                   done,
  output logic                   illegal,
  output logic                   branch_taken,
  output logic [31:0]            next_pc,
  // Byte store
  output logic                   byte_wr,
  output logic [7:0]             byte_wr_data,
  output logic [5:0]             byte_wr_ea,
  // Coprocessor interface
  ccbs_cir_if.dev                cir
);
  import ccbs_pkg::*;

  function automatic logic [31:0] step_word(input logic [31:0] addr);
    step_word = addr + CCBS_WORD_STEP;
  endfunction : step_word

  ccbs_dev_state_e state;
  logic [15:0]     opcode;
  logic [31:0]     instruction_scan_counter;
  logic [31:0]     disp_base;
  logic [15:0]     disp_hi;
  logic [15:0]     disp_lo;
  logic            disp_second;
  logic            cond_true;
  logic [2:0]      ea_left;
  logic            cir_req;
  logic            cir_write;
  logic [1:0]      cir_sel;
  logic [2:0]      cir_addr_id;
  logic [15:0]     cir_wdata;

  // ****************************************
  // Opcode decode
  // ****************************************
  wire logic        take_word        = iw_valid & iw_ready;
  wire logic        is_fline         = iw_data[CCBS_FLINE_MSB:CCBS_FLINE_LSB] == CCBS_FLINE;
  wire logic [2:0]  coprocessor_select_field = iw_data[CCBS_ID_MSB:CCBS_ID_LSB];
  wire logic [2:0]  in_type          = iw_data[CCBS_TYPE_MSB:CCBS_TYPE_LSB];
  wire logic        in_set_byte      = in_type == CCBS_TYPE_SET_BYTE;
  wire logic        in_branch        = (in_type == CCBS_TYPE_BR_SHORT) |
                                       (in_type == CCBS_TYPE_BR_LONG);
  wire logic [2:0]  op_type          = opcode[CCBS_TYPE_MSB:CCBS_TYPE_LSB];
  wire logic        set_byte_on_condition = op_type == CCBS_TYPE_SET_BYTE;
  wire logic        cond_branch_long_disp = op_type == CCBS_TYPE_BR_LONG;
  wire logic [1:0]  prim             = cir.cir_rdata[CCBS_PRIM_MSB:CCBS_PRIM_LSB];
  wire logic [2:0]  ea_count         = (ea_ext_count > CCBS_EA_EXT_MAX) ? CCBS_EA_EXT_MAX : ea_ext_count;
  wire logic [31:0] branch_target;

  ccbs_branch_target ccbs_branch_target_i (
    .disp_long   (cond_branch_long_disp),
    .disp_hi     (disp_hi),
    .disp_lo     (disp_lo),
    .base_addr   (disp_base),
    .target_addr (branch_target)
  );

  // ****************************************
  // Interface register outputs
  // ****************************************
  assign cir.cir_req     = cir_req;
  assign cir.cir_write   = cir_write;
  assign cir.cir_sel     = cir_sel;
  assign cir.cir_addr_id = cir_addr_id;
  assign cir.cir_wdata   = cir_wdata;

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state                    <= DEV_IDLE;
      opcode                   <= 16'h0000;
      instruction_scan_counter <= 32'h0000_0000;
      disp_base                <= 32'h0000_0000;
      disp_hi                  <= 16'h0000;
      disp_lo                  <= 16'h0000;
      disp_second              <= 1'b0;
      cond_true                <= 1'b0;
      ea_left                  <= 3'h0;
      iw_ready                 <= 1'b0;
      done                     <= 1'b0;
      illegal                  <= 1'b0;
      branch_taken             <= 1'b0;
      next_pc                  <= 32'h0000_0000;
      byte_wr                  <= 1'b0;
      byte_wr_data             <= 8'h00;
      byte_wr_ea               <= 6'h00;
      cir_req                  <= 1'b0;
      cir_write                <= 1'b0;
      cir_sel                  <= CCBS_CIR_COND;
      cir_addr_id              <= 3'h0;
      cir_wdata                <= 16'h0000;
    end else begin
      done    <= 1'b0;
      byte_wr <= 1'b0;
      case (state)
        DEV_IDLE: begin
          if (start) begin
            instruction_scan_counter <= pc_start;
            illegal                  <= 1'b0;
            branch_taken             <= 1'b0;
            iw_ready                 <= 1'b1;
            state                    <= DEV_OPCODE;
          end
        end
        DEV_OPCODE: begin
          if (take_word) begin
            opcode                   <= iw_data;
            instruction_scan_counter <= step_word(instruction_scan_counter);
            cir_addr_id              <= coprocessor_select_field;
            if (!is_fline || !(in_set_byte || in_branch)) begin
              iw_ready <= 1'b0;
              illegal  <= 1'b1;
              state    <= DEV_FINISH;
            end else if (in_set_byte) begin
              state <= DEV_SELECTOR;
            end else begin
              iw_ready  <= 1'b0;
              cir_req   <= 1'b1;
              cir_write <= 1'b1;
              cir_sel   <= CCBS_CIR_COND;
              cir_wdata <= iw_data;
              state     <= DEV_WR_COND;
            end
          end
        end
        DEV_SELECTOR: begin
          if (take_word) begin
            iw_ready                 <= 1'b0;
            instruction_scan_counter <= step_word(instruction_scan_counter);
            cir_req                  <= 1'b1;
            cir_write                <= 1'b1;
            cir_sel                  <= CCBS_CIR_COND;
            cir_wdata                <= iw_data;
            state                    <= DEV_WR_COND;
          end
        end
        DEV_WR_COND, DEV_WR_OPND: begin
          if (cir.cir_ack) begin
            cir_write <= 1'b0;
            cir_sel   <= CCBS_CIR_RESP;
            state     <= DEV_RD_RESP;
          end
        end
        DEV_RD_RESP: begin
          if (cir.cir_ack) begin
            case (prim)
              CCBS_PRIM_XFER: begin
                cir_req  <= 1'b0;
                iw_ready <= 1'b1;
                state    <= DEV_EXT;
              end
              CCBS_PRIM_NULL: begin
                cir_req     <= 1'b0;
                cond_true   <= cir.cir_rdata[0];
                disp_second <= 1'b0;
                ea_left     <= ea_count;
                if (set_byte_on_condition && ea_count == 3'h0) begin
                  state <= DEV_FINISH;
                end else begin
                  iw_ready <= 1'b1;
                  state    <= set_byte_on_condition ? DEV_EA_EXT : DEV_DISP;
                end
              end
              default: begin
                cir_req <= 1'b1;
              end
            endcase
          end
        end
        DEV_EXT: begin
          if (take_word) begin
            iw_ready                 <= 1'b0;
            instruction_scan_counter <= step_word(instruction_scan_counter);
            cir_req                  <= 1'b1;
            cir_write                <= 1'b1;
            cir_sel                  <= CCBS_CIR_OPND;
            cir_wdata                <= iw_data;
            state                    <= DEV_WR_OPND;
          end
        end
        DEV_DISP: begin
          if (take_word) begin
            instruction_scan_counter <= step_word(instruction_scan_counter);
            if (!disp_second) begin
              disp_base <= instruction_scan_counter;
              disp_hi   <= iw_data;
            end else begin
              disp_lo <= iw_data;
            end
            disp_second <= 1'b1;
            if (disp_second || !cond_branch_long_disp) begin
              iw_ready <= 1'b0;
              state    <= DEV_FINISH;
            end
          end
        end
        DEV_EA_EXT: begin
          if (take_word) begin
            instruction_scan_counter <= step_word(instruction_scan_counter);
            ea_left                  <= ea_left - 3'h1;
            if (ea_left == 3'h1) begin
              iw_ready <= 1'b0;
              state    <= DEV_FINISH;
            end
          end
        end
        DEV_FINISH: begin
          done  <= 1'b1;
          state <= DEV_IDLE;
          if (illegal) begin
            next_pc <= instruction_scan_counter;
          end else if (set_byte_on_condition) begin
            byte_wr      <= 1'b1;
            byte_wr_ea   <= opcode[CCBS_SEL_MSB:0];
            byte_wr_data <= cond_true ? CCBS_BYTE_TRUE : CCBS_BYTE_FALSE;
            next_pc      <= instruction_scan_counter;
          end else begin
            branch_taken <= cond_true;
            next_pc      <= cond_true ? branch_target : instruction_scan_counter;
          end
        end
        default: begin
          state <= DEV_IDLE;
        end
      endcase
    end
  end

endmodule : ccbs_dev

// file: hw/ccbs_cop.sv
`timescale 1ns/1ns
module ccbs_cop #(
  parameter logic [2:0] CP_ID       = ccbs_pkg::CCBS_DEF_CP_ID,
  parameter int         EXT_WORDS   = ccbs_pkg::CCBS_DEF_EXT_WORDS,
  parameter int         EVAL_CYCLES = ccbs_pkg::CCBS_DEF_EVAL_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Interface registers
  ccbs_cir_if.cop          cir,
  // Condition evaluation
  output logic             cond_sel_valid,
  output logic [5:0]       cond_sel,
  input  wire logic        cond_result,
  // Extension words
  output logic             ext_valid,
  output logic [15:0]      ext_word
);
  import ccbs_pkg::*;

  ccbs_cop_state_e state;
  logic [7:0]      ext_left;
  logic [7:0]      eval_left;
  logic            result;
  logic [15:0]     coproc_interface_register;

  wire logic hit      = cir.cir_req & ~cir.cir_ack & (cir.cir_addr_id == CP_ID);
  wire logic wr_cond  = hit & cir.cir_write & (cir.cir_sel == CCBS_CIR_COND);
  wire logic wr_opnd  = hit & cir.cir_write & (cir.cir_sel == CCBS_CIR_OPND);
  wire logic rd_resp  = hit & ~cir.cir_write & (cir.cir_sel == CCBS_CIR_RESP);
  wire logic [15:0] resp_word = (state == COP_XFER) ? CCBS_RESP_XFER :
                                (state == COP_DONE) ? (result ? CCBS_RESP_TRUE : CCBS_RESP_FALSE) :
                                CCBS_RESP_BUSY;

  // ****************************************
  // Register access and evaluation
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state                     <= COP_IDLE;
      ext_left                  <= 8'h00;
      eval_left                 <= 8'h00;
      result                    <= 1'b0;
      coproc_interface_register <= 16'h0000;
      cir.cir_ack               <= 1'b0;
      cir.cir_rdata             <= 16'h0000;
      cond_sel_valid            <= 1'b0;
      cond_sel                  <= 6'h00;
      ext_valid                 <= 1'b0;
      ext_word                  <= 16'h0000;
    end else begin
      cir.cir_ack    <= hit;
      cond_sel_valid <= 1'b0;
      ext_valid      <= 1'b0;
      if (rd_resp) begin
        cir.cir_rdata <= resp_word;
        if (state == COP_DONE) begin
          state <= COP_IDLE;
        end
      end
      if (wr_cond) begin
        coproc_interface_register <= cir.cir_wdata;
        cond_sel                  <= cir.cir_wdata[CCBS_SEL_MSB:0];
        ext_left                  <= 8'(EXT_WORDS);
        state                     <= (EXT_WORDS == 0) ? COP_EVAL : COP_XFER;
        eval_left                 <= 8'(EVAL_CYCLES);
        cond_sel_valid            <= (EXT_WORDS == 0);
      end else if (wr_opnd && state == COP_XFER) begin
        ext_valid <= 1'b1;
        ext_word  <= cir.cir_wdata;
        ext_left  <= ext_left - 8'h01;
        if (ext_left == 8'h01) begin
          state          <= COP_EVAL;
          cond_sel_valid <= 1'b1;
        end
      end else if (state == COP_EVAL) begin
        if (eval_left == 8'h00) begin
          result <= cond_result;
          state  <= COP_DONE;
        end else begin
          eval_left <= eval_left - 8'h01;
        end
      end
    end
  end

endmodule : ccbs_cop

// file: bench/ccbs_sva.sv
`timescale 1ns/1ns
module ccbs_sva
  import ccbs_pkg::*;
#(
  parameter logic [2:0] CP_ID = CCBS_DEF_CP_ID
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Interface registers
  input wire logic        cir_req,
  input wire logic        cir_write,
  input wire logic [1:0]  cir_sel,
  input wire logic [2:0]  cir_addr_id,
  input wire logic [15:0] cir_wdata,
  input wire logic [15:0] cir_rdata,
  input wire logic        cir_ack
);
  // ****
  // Decode
  // ****
  wire logic       resp_ack;
  wire logic [1:0] prim;
  wire logic       resp_rd;
  assign resp_ack = cir_ack && !cir_write && (cir_sel == CCBS_CIR_RESP);
  assign prim     = cir_rdata[CCBS_PRIM_MSB:CCBS_PRIM_LSB];
  assign resp_rd  = cir_req && !cir_write && (cir_sel == CCBS_CIR_RESP);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ****
  // Checks
  // ****
  a_req_holds: assert property (
    cir_req && !cir_ack |=> cir_req && $stable(cir_write) && $stable(cir_sel)
      && $stable(cir_wdata) && $stable(cir_addr_id))
    else $error("request changed before ack");
  a_id_driven: assert property (
    cir_req |-> cir_addr_id == CP_ID) else $error("wrong id on access");
  a_ack_answer: assert property (
    cir_req && !cir_ack |=> cir_ack) else $error("access not acked");
  a_ack_pulse: assert property (
    cir_ack |=> !cir_ack) else $error("ack longer than one cycle");
  a_resp_after_cond: assert property (
    cir_ack && cir_write && cir_sel == CCBS_CIR_COND |-> ##[1:2] resp_rd)
    else $error("no response read after condition write");
  a_busy_reread: assert property (
    resp_ack && prim == CCBS_PRIM_BUSY |-> ##[1:2] resp_rd)
    else $error("busy not re-read");
  a_xfer_operand: assert property (
    resp_ack && prim == CCBS_PRIM_XFER |-> ##[1:8] (cir_req && cir_write && cir_sel == CCBS_CIR_OPND))
    else $error("transfer request not serviced");
  a_null_release: assert property (
    resp_ack && prim == CCBS_PRIM_NULL |=> !cir_req [*4])
    else $error("access after final result");
  a_null_result: assert property (
    resp_ack && prim == CCBS_PRIM_NULL |-> cir_rdata == CCBS_RESP_FALSE || cir_rdata == CCBS_RESP_TRUE)
    else $error("bad final result word");
  a_resp_read_only: assert property (
    cir_req && cir_sel == CCBS_CIR_RESP |-> !cir_write) else $error("write to response register");
  c_xfer: cover property (resp_ack && prim == CCBS_PRIM_XFER);
endmodule : ccbs_sva

// file: bench/tb.sv
`timescale 1ns/1ns
module tb;
  import ccbs_pkg::*;
  typedef struct packed {
    logic        ill;
    logic        taken;
    logic        wr;
    logic [7:0]  data;
    logic [5:0]  ea;
    logic        use_pc;
    logic [31:0] pc;
  } ccbs_exp_s;
  localparam logic [2:0] TB_ID = 3'h5;
  logic        core_clk, rst, start, iw_valid, cond_result;
  logic [31:0] pc_start;
  logic [2:0]  ea_ext_count;
  logic [15:0] iw_data;
  logic        iw_ready, done, illegal, branch_taken, byte_wr, cond_sel_valid, ext_valid;
  logic [31:0] next_pc;
  logic [7:0]  byte_wr_data;
  logic [5:0]  byte_wr_ea, cond_sel;
  logic [15:0] ext_word;
  logic [15:0] wq[$];
  logic [15:0] xq[$];
  logic [5:0]  sq[$];
  ccbs_exp_s   eq[$];
  ccbs_exp_s   e;
  int          err_total, check_count, cyc, acks;
  int          ilt[5] = '{0, 4, 5, 6, 7};

  ccbs_cir_if cir_bus();
  ccbs_dev ccbs_dev_i (.core_clk, .rst, .start, .pc_start, .ea_ext_count, .iw_valid, .iw_data,
    .iw_ready, .done, .illegal, .branch_taken, .next_pc, .byte_wr, .byte_wr_data, .byte_wr_ea,
    .cir(cir_bus.dev));
  ccbs_cop #(.CP_ID(TB_ID), .EXT_WORDS(1)) ccbs_cop_i (.core_clk, .rst, .cir(cir_bus.cop),
    .cond_sel_valid, .cond_sel, .cond_result, .ext_valid, .ext_word);
  ccbs_sva #(.CP_ID(TB_ID)) ccbs_sva_i (.core_clk, .rst, .cir_req(cir_bus.cir_req),
    .cir_write(cir_bus.cir_write), .cir_sel(cir_bus.cir_sel), .cir_addr_id(cir_bus.cir_addr_id),
    .cir_wdata(cir_bus.cir_wdata), .cir_rdata(cir_bus.cir_rdata), .cir_ack(cir_bus.cir_ack));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task test_done;
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // ****
  // Word stream, monitors, timeout
  // ****
  always @(negedge core_clk) begin
    iw_valid <= (wq.size() > 0);
    iw_data  <= (wq.size() > 0) ? wq[0] : 16'($urandom());
  end
  always @(posedge core_clk) begin
    if (iw_valid && iw_ready) void'(wq.pop_front());
    if (cir_bus.cir_ack === 1'b1) acks++;
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end
  always @(negedge core_clk) begin
    if (cond_sel_valid === 1'b1) check("cond_sel", 32'(cond_sel), 32'(sq.pop_front()));
    if (ext_valid === 1'b1) check("ext_word", 32'(ext_word), 32'(xq.pop_front()));
    if (done === 1'b1) begin
      e = eq.pop_front();
      check("illegal", 32'(illegal), 32'(e.ill));
      check("branch_taken", 32'(branch_taken), 32'(e.taken));
      check("byte_wr", 32'(byte_wr), 32'(e.wr));
      check("words_left", 32'(wq.size()), 32'h0);
      if (e.wr) check("byte_wr_data", 32'(byte_wr_data), 32'(e.data));
      if (e.wr) check("byte_wr_ea", 32'(byte_wr_ea), 32'(e.ea));
      if (e.use_pc) check("next_pc", next_pc, e.pc);
    end
  end

  // ****
  // One instruction
  // ****
  task automatic run(input logic [15:0] op, input logic [15:0] sw, input logic res,
                     input logic [31:0] disp, input logic [2:0] n);
    ccbs_exp_s   x;
    logic [31:0] p;
    logic [15:0] xw;
    int          k;
    int          a0;
    p  = $urandom() & 32'hffff_fffe;
    xw = 16'($urandom());
    x  = '0;
    wq.push_back(op);
    if (op[15:12] !== CCBS_FLINE || !(op[8:6] inside {3'h1, 3'h2, 3'h3})) begin
      x.ill = 1'b1;
    end else if (op[8:6] == CCBS_TYPE_SET_BYTE) begin
      k = (n > 3'h5) ? 5 : int'(n);
      wq.push_back(sw);
      sq.push_back(sw[5:0]);
      wq.push_back(xw);
      xq.push_back(xw);
      repeat (k) wq.push_back(16'($urandom()));
      x.use_pc = 1'b1;
      x.wr     = 1'b1;
      x.data   = res ? CCBS_BYTE_TRUE : CCBS_BYTE_FALSE;
      x.ea     = op[5:0];
      x.pc     = p + 32'(2 * (3 + k));
    end else begin
      sq.push_back(op[5:0]);
      wq.push_back(xw);
      xq.push_back(xw);
      x.use_pc = 1'b1;
      x.taken  = res;
      if (op[8:6] == CCBS_TYPE_BR_LONG) begin
        wq.push_back(disp[31:16]);
        wq.push_back(disp[15:0]);
        x.pc = p + 32'h4 + (res ? disp : 32'h4);
      end else begin
        wq.push_back(disp[15:0]);
        x.pc = p + 32'h4 + (res ? {{16{disp[15]}}, disp[15:0]} : 32'h2);
      end
    end
    eq.push_back(x);
    @(negedge core_clk);
    start        <= 1'b1;
    pc_start     <= p;
    ea_ext_count <= n;
    cond_result  <= res;
    a0 = acks;
    @(negedge core_clk);
    start <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    if (done !== 1'b1) check("done", 32'(done), 32'h1);
    if (x.ill) check("cir_acks", 32'(acks - a0), 32'h0);
    repeat (3) @(negedge core_clk);
  endtask : run

  initial begin
    err_total = 0;
    check_count = 0;
    cyc = 0;
    acks = 0;
    rst = 1'b1;
    start = 1'b0;
    pc_start = 32'h0;
    ea_ext_count = 3'h0;
    iw_valid = 1'b0;
    iw_data = 16'h0;
    cond_result = 1'b0;
    void'($urandom(35));
    repeat (5) @(negedge core_clk);
    rst <= 1'b0;
    run(16'h7123, 16'h0, 1'b1, 32'h0, 3'h0);
    for (int j = 0; j < 5; j++) run({4'hf, TB_ID, 3'(ilt[j]), 6'h2a}, 16'h0, 1'b1, 32'h0, 3'h0);
    run({4'hf, TB_ID, CCBS_TYPE_BR_SHORT, 6'h3f}, 16'h0, 1'b1, 32'h0000_8000, 3'h0);
    run({4'hf, TB_ID, CCBS_TYPE_BR_LONG, 6'h00}, 16'h0, 1'b1, 32'hffff_fffe, 3'h0);
    for (int i = 0; i < 16; i++)
      run({4'hf, TB_ID, (i[0] ? CCBS_TYPE_BR_LONG : CCBS_TYPE_BR_SHORT), 6'($urandom())},
          16'h0, i[1], $urandom(), 3'h0);
    for (int m = 0; m < 8; m++)
      run({4'hf, TB_ID, CCBS_TYPE_SET_BYTE, 6'($urandom())}, 16'($urandom()), m[0], 32'h0, 3'(m));
    test_done();
  end
endmodule : tb
